// File: hdl/mscm_consts.vh
// Purpose: shared constants for the motion step chaining monitor
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef MSCM_CONSTS_VH
`define MSCM_CONSTS_VH
// ----------------------------------------
// jump field codes
// ----------------------------------------
`define MSCM_JMP_STOP 8'h00
`define MSCM_JMP_SEQ 8'hA0
`define MSCM_JMP_RET 8'hB0
`define MSCM_JMP_MIN 8'h01
`define MSCM_JMP_MAX 8'h44
`define MSCM_JMP_LSB 16
// ----------------------------------------
// interrupt policy values
// ----------------------------------------
`define MSCM_POL_IGNORE 2'h0
`define MSCM_POL_AFTER 2'h1
`define MSCM_POL_ABORT 2'h2
// ----------------------------------------
// Avalon register byte addresses (word aligned)
// ----------------------------------------
`define MSCM_A_CTRL 6'h00
`define MSCM_A_STROKE 6'h04
`define MSCM_A_SCALE 6'h08
`define MSCM_A_STAT 6'h0C
`define MSCM_A_IRQ 6'h10
`define MSCM_A_MASK 6'h14
`define MSCM_A_SPOS 6'h18
`define MSCM_A_CPOS 6'h1C
`define MSCM_A_SIDX 6'h20
`define MSCM_A_CIDX 6'h24
`define MSCM_A_CDP 6'h28
`define MSCM_A_FBP 6'h2C
`define MSCM_A_CMD 6'h30
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define MSCM_C_MODE 0
`define MSCM_C_OVL 1
`define MSCM_C_POL 2
`define MSCM_I_DONE 0
`define MSCM_I_STOP 1
`define MSCM_I_CAP 2
`define MSCM_STROKE_RST 32'h00000000
`define MSCM_SCALE_RST 16'h0001
`define MSCM_SCALE_FIX 16'h0001
`define MSCM_DEAD 32'hDEADC0DE
`endif

// File: hdl/mscm_modulo.v
// Purpose: sequential remainder of a position by the index stroke
// Assumes: stroke zero means no indexing, remainder equals input
// Notes: one bit per cycle restoring division, result held until next start
`timescale 1ns/1ps
module mscm_modulo #(
	parameter W = 32 // operand width
) (
	input wire sys_clk, // system clock
	input wire sys_rst, // sync reset, active high
	input wire start, // pulse: begin a remainder
	input wire signed [W-1:0] value, // dividend, signed
	input wire [W-1:0] stroke, // divisor
	output reg [W-1:0] rem, // remainder result
	output reg done // pulse: result valid
);
	reg [W-1:0] dvd; // shifting dividend magnitude
	reg [W:0] acc; // partial remainder
	reg [5:0] cnt; // bit counter
	reg busy; // division running
	reg neg; // dividend was negative
	reg [W-1:0] sor; // latched divisor
	wire [W:0] trial = {acc[W-1:0], dvd[W-1]} - {1'b0, sor}; // trial subtract
	wire [W-1:0] mag = value[W-1] ? (~value + 1'b1) : value; // magnitude
	wire [W:0] shf = {acc[W-1:0], dvd[W-1]}; // shifted remainder
	// ----------------------------------------
	// division engine
	// ----------------------------------------
	always @(posedge sys_clk) begin
		done <= 1'b0;
		if (sys_rst) begin
			dvd <= {W{1'b0}};
			acc <= {(W+1){1'b0}};
			cnt <= 6'h00;
			busy <= 1'b0;
			neg <= 1'b0;
			sor <= {W{1'b0}};
			rem <= {W{1'b0}};
		end else if (start && !busy) begin
			if (stroke == {W{1'b0}}) begin
				rem <= value; // no indexing stroke
				done <= 1'b1;
			end else begin
				dvd <= mag;
				neg <= value[W-1];
				sor <= stroke;
				acc <= {(W+1){1'b0}};
				cnt <= W[5:0];
				busy <= 1'b1;
			end
		end else if (busy) begin
			dvd <= {dvd[W-2:0], 1'b0};
			acc <= trial[W] ? shf : trial; // restore on borrow
			cnt <= cnt - 6'h01;
			if (cnt == 6'h01) begin
				busy <= 1'b0;
				done <= 1'b1;
				// negative positions wrap into 0..stroke-1
				if (trial[W]) begin
					rem <= (neg && shf[W-1:0] != {W{1'b0}}) ? sor - shf[W-1:0] : shf[W-1:0];
				end else begin
					rem <= (neg && trial[W-1:0] != {W{1'b0}}) ? sor - trial[W-1:0] : trial[W-1:0];
				end
			end
		end
	end
endmodule // mscm_modulo

// File: hdl/mscm_top.v
// Purpose: stored-command sequencer and coordinate monitors
// Assumes: positions from drive logic on sys_clk, Avalon-MM slave
// Notes: servo_on, trigger_req and cmd_decel are pins, three-flop synchronised
// What this block does
// RL1: stop code ends sequence, busy drops
// RL2: sequential code starts next higher command
// RL3: return code resumes previously interrupted command
// RL4: codes 1..68 start that command number
// RL5: monitor pulse scale applies only in mode
// RL6: servo-on edge captures start position
// RL7: current position monitor follows position every cycle in mode
// RL8: start index is start position modulo stroke
// RL9: current index is position modulo stroke
// RL10: commanded count is current minus start
// RL11: feedback count is capture plus displacement
// RL12: overlap starts next command at deceleration
// RL13: interrupt policy ignores, defers or aborts triggers
// RL14: undefined jump codes behave as stop
`timescale 1ns/1ps
`include "mscm_consts.vh"
module mscm_top #(
	parameter W = 32 // position width
) (
	input wire sys_clk, // 25 MHz clock
	input wire sys_rst, // sync reset, active high
	input wire [5:0] avs_address, // byte address
	input wire avs_read, // read strobe
	input wire avs_write, // write strobe
	input wire [31:0] avs_writedata, // write data
	input wire [3:0] avs_byteenable, // byte lanes
	output reg [31:0] avs_readdata, // read data
	output reg avs_waitrequest, // wait while not answered
	input wire signed [W-1:0] abs_position, // command position, user units
	input wire signed [W-1:0] encoder_position, // feedback position at servo-on
	input wire servo_on, // pin: servo enabled
	input wire trigger_req, // pin: level, trigger request
	input wire [6:0] trigger_cmd, // requested command number
	input wire cmd_done, // pulse: running command complete
	input wire cmd_decel, // pin: running command decelerating
	input wire [31:0] cmd_word, // mode word of the running command
	output reg [6:0] cmd_number, // command to execute
	output reg cmd_start, // pulse: start cmd_number
	output reg cmd_abort, // pulse: abort running command
	output reg sequence_busy_output, // sequence running
	output reg sequence_delay_output, // delay time running
	output reg [15:0] monitor_pulse_scale_out, // scale in use
	output reg irq // level interrupt
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg mode_en; // stored-command mode
	reg overlap_en; // overlap connection
	reg [1:0] interrupt_policy_setting; // trigger policy
	reg [W-1:0] total_index_stroke; // index stroke
	reg [15:0] monitor_pulse_scale; // scale parameter
	reg [2:0] irq_stat; // sticky events
	reg [2:0] irq_mask; // enables
	reg signed [W-1:0] start_position_monitor; // start position
	reg signed [W-1:0] current_position_monitor; // current position
	reg [W-1:0] start_index_monitor; // start index
	reg [W-1:0] current_index_monitor; // current index
	reg signed [W-1:0] commanded_pulse_count; // displacement
	reg signed [W-1:0] feedback_pulse_count; // feedback count
	reg signed [W-1:0] fb_capture; // encoder at servo-on
	reg [6:0] prev_cmd; // command to return to
	reg [6:0] pend_cmd; // deferred trigger command
	reg pend_valid; // deferred trigger present
	reg ovl_taken; // deceleration of this command already used for a chain
	reg ovl_run; // running command was chained at deceleration
	reg u_busy; // modulo in flight
	reg [2:0] son_s, trg_s, dec_s; // pin synchronisers
	reg son_q, trg_q; // previous agreed levels
	reg sidx_phase; // modulo busy on start index
	reg mod_start; // pulse to modulo unit
	reg signed [W-1:0] mod_value; // modulo operand
	reg cap_pend; // start index pending
	wire [W-1:0] mod_rem; // modulo result
	wire mod_done; // modulo result valid
	wire [7:0] jump = cmd_word[`MSCM_JMP_LSB+7:`MSCM_JMP_LSB]; // jump field
	wire son_rise = son_s[2] & son_s[1] & ~son_q; // servo-on edge
	wire trg_rise = trg_s[2] & trg_s[1] & ~trg_q; // trigger edge
	wire decel = dec_s[2] & dec_s[1]; // agreed decel level
	// something follows this command: a deferred trigger or a chaining code
	wire jump_chains = pend_valid || jump == `MSCM_JMP_SEQ || jump == `MSCM_JMP_RET ||
		(jump >= `MSCM_JMP_MIN && jump <= `MSCM_JMP_MAX);
	wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}}; // lane mask
	wire [31:0] wdat = avs_writedata & be_mask; // masked data
	// a write lands at the edge where the master sees waitrequest low
	wire wr = avs_write & ~avs_waitrequest; // write lands this cycle
	wire rd = avs_read & avs_waitrequest; // read taken this cycle
	reg [2:0] ev; // events, one cycle late into the status
	// ----------------------------------------
	// shared modulo unit for index monitors
	// ----------------------------------------
	mscm_modulo #(.W(W)) u_mod (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.start(mod_start),
		.value(mod_value),
		.stroke(total_index_stroke),
		.rem(mod_rem),
		.done(mod_done)
	);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			son_s <= 3'h0;
			trg_s <= 3'h0;
			dec_s <= 3'h0;
			son_q <= 1'b0;
			trg_q <= 1'b0;
		end else begin
			son_s <= {son_s[1:0], servo_on};
			trg_s <= {trg_s[1:0], trigger_req};
			dec_s <= {dec_s[1:0], cmd_decel};
			if (son_s[2] == son_s[1]) son_q <= son_s[2]; // agreed level
			if (trg_s[2] == trg_s[1]) trg_q <= trg_s[2];
		end
	end
	// ----------------------------------------
	// sequencer: completion, jump and triggers
	// ----------------------------------------
	always @(posedge sys_clk) begin
		cmd_start <= 1'b0;
		cmd_abort <= 1'b0;
		ev <= 3'h0;
		if (sys_rst) begin
			cmd_number <= 7'h00;
			sequence_busy_output <= 1'b0;
			sequence_delay_output <= 1'b0;
			prev_cmd <= 7'h00;
			pend_cmd <= 7'h00;
			pend_valid <= 1'b0;
			ovl_taken <= 1'b0;
			ovl_run <= 1'b0;
		end else if (!mode_en) begin
			sequence_busy_output <= 1'b0;
			pend_valid <= 1'b0;
		end else if (trg_rise && !sequence_busy_output) begin
			cmd_number <= trigger_cmd; // idle: start at once
			cmd_start <= 1'b1;
			sequence_busy_output <= 1'b1;
			sequence_delay_output <= 1'b0;
			ovl_taken <= 1'b0;
			ovl_run <= 1'b0;
		end else begin
			// one deceleration chains once; rearm when its level has gone
			if (!decel) ovl_taken <= 1'b0;
			if (trg_rise && interrupt_policy_setting == `MSCM_POL_ABORT) begin
				prev_cmd <= cmd_number; // remember interrupted [RL3]
				cmd_number <= trigger_cmd;
				cmd_abort <= 1'b1; // abort and connect [RL13]
				cmd_start <= 1'b1;
				sequence_delay_output <= 1'b0;
				ovl_taken <= 1'b0;
				ovl_run <= 1'b0;
			end else begin
				if (trg_rise && interrupt_policy_setting == `MSCM_POL_AFTER) begin
					pend_cmd <= trigger_cmd; // deferred [RL13]
					pend_valid <= 1'b1;
				end
				// policy 0 ignores triggers while busy, completion still runs [RL13]
				// a done while ovl_taken belongs to the command left at deceleration
				if (sequence_busy_output && !ovl_taken && (cmd_done ||
					(overlap_en && decel && jump_chains))) begin
					// next command, on completion or at deceleration [RL12]
					ev[`MSCM_I_DONE] <= 1'b1;
					ovl_taken <= !cmd_done;
					ovl_run <= !cmd_done;
					// delay follows only the completion of an overlapped command [RL12]
					sequence_delay_output <= cmd_done && ovl_run;
					if (pend_valid) begin
						cmd_number <= pend_cmd; // overrides jump field [RL13]
						cmd_start <= 1'b1;
						pend_valid <= 1'b0;
					end else if (jump == `MSCM_JMP_SEQ) begin
						cmd_number <= cmd_number + 7'h01; // [RL2]
						cmd_start <= 1'b1;
					end else if (jump == `MSCM_JMP_RET) begin
						cmd_number <= prev_cmd; // [RL3]
						cmd_start <= 1'b1;
					end else if (jump >= `MSCM_JMP_MIN && jump <= `MSCM_JMP_MAX) begin
						cmd_number <= jump[6:0]; // [RL4]
						cmd_start <= 1'b1;
					end else begin
						// stop code and undefined codes [RL1] [RL14]
						sequence_busy_output <= 1'b0;
						ev[`MSCM_I_STOP] <= 1'b1;
					end
				end
			end
		end
		if (son_rise && mode_en) ev[`MSCM_I_CAP] <= 1'b1;
	end
	// ----------------------------------------
	// coordinate monitors
	// ----------------------------------------
	always @(posedge sys_clk) begin
		mod_start <= 1'b0;
		if (sys_rst) begin
			start_position_monitor <= {W{1'b0}};
			current_position_monitor <= {W{1'b0}};
			start_index_monitor <= {W{1'b0}};
			current_index_monitor <= {W{1'b0}};
			commanded_pulse_count <= {W{1'b0}};
			feedback_pulse_count <= {W{1'b0}};
			fb_capture <= {W{1'b0}};
			mod_value <= {W{1'b0}};
			sidx_phase <= 1'b0;
			cap_pend <= 1'b0;
		end else if (mode_en) begin
			current_position_monitor <= abs_position; // [RL7]
			commanded_pulse_count <= current_position_monitor - start_position_monitor; // [RL10]
			feedback_pulse_count <= fb_capture + commanded_pulse_count; // [RL11]
			if (son_rise) begin
				start_position_monitor <= abs_position; // [RL6]
				fb_capture <= encoder_position;
				cap_pend <= 1'b1;
			end
			if (mod_done) begin
				if (sidx_phase) start_index_monitor <= mod_rem; // [RL8]
				else current_index_monitor <= mod_rem; // [RL9]
			end
			// unit idle: next pass, a pending start index goes first
			if (!mod_start && !u_busy) begin
				mod_start <= 1'b1;
				sidx_phase <= cap_pend;
				if (cap_pend) begin
					mod_value <= start_position_monitor; // start index pass
					cap_pend <= son_rise;
				end else begin
					mod_value <= current_position_monitor; // current index pass
				end
			end
		end
	end
	// modulo unit idle tracker
	always @(posedge sys_clk) begin
		if (sys_rst) u_busy <= 1'b0;
		else if (mod_start) u_busy <= 1'b1;
		else if (mod_done) u_busy <= 1'b0;
	end
	// ----------------------------------------
	// scale, interrupt output
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			monitor_pulse_scale_out <= `MSCM_SCALE_FIX;
			irq <= 1'b0;
		end else begin
			monitor_pulse_scale_out <= mode_en ? monitor_pulse_scale : `MSCM_SCALE_FIX; // [RL5]
			irq <= |(irq_stat & irq_mask);
		end
	end
	// ----------------------------------------
	// Avalon slave: one wait cycle then answer
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
			mode_en <= 1'b0;
			overlap_en <= 1'b0;
			interrupt_policy_setting <= `MSCM_POL_IGNORE;
			total_index_stroke <= `MSCM_STROKE_RST;
			monitor_pulse_scale <= `MSCM_SCALE_RST;
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
		end else begin
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
			// set wins over write-one clear
			irq_stat <= (irq_stat & ~((wr && avs_address == `MSCM_A_IRQ) ?
				wdat[2:0] : 3'h0)) | ev;
			if (wr) begin
				case (avs_address)
					`MSCM_A_CTRL: begin
						mode_en <= wdat[`MSCM_C_MODE];
						overlap_en <= wdat[`MSCM_C_OVL];
						interrupt_policy_setting <= wdat[`MSCM_C_POL+1:`MSCM_C_POL];
					end
					`MSCM_A_STROKE: total_index_stroke <= wdat[W-1:0];
					`MSCM_A_SCALE: monitor_pulse_scale <= wdat[15:0];
					`MSCM_A_MASK: irq_mask <= wdat[2:0];
					default: ;
				endcase
			end
			if (rd) begin
				case (avs_address)
					`MSCM_A_CTRL: avs_readdata <= {28'h0000000, interrupt_policy_setting,
						overlap_en, mode_en};
					`MSCM_A_STROKE: avs_readdata <= total_index_stroke;
					`MSCM_A_SCALE: avs_readdata <= {16'h0000, monitor_pulse_scale};
					`MSCM_A_STAT: avs_readdata <= {29'h00000000, pend_valid,
						sequence_delay_output, sequence_busy_output};
					`MSCM_A_IRQ: avs_readdata <= {29'h00000000, irq_stat};
					`MSCM_A_MASK: avs_readdata <= {29'h00000000, irq_mask};
					`MSCM_A_SPOS: avs_readdata <= start_position_monitor;
					`MSCM_A_CPOS: avs_readdata <= current_position_monitor;
					`MSCM_A_SIDX: avs_readdata <= start_index_monitor;
					`MSCM_A_CIDX: avs_readdata <= current_index_monitor;
					`MSCM_A_CDP: avs_readdata <= commanded_pulse_count;
					`MSCM_A_FBP: avs_readdata <= feedback_pulse_count;
					`MSCM_A_CMD: avs_readdata <= {25'h0000000, cmd_number};
					default: avs_readdata <= `MSCM_DEAD; // unmapped
				endcase
			end
		end
	end
endmodule // mscm_top

// File: verif/mscm_top_props.sv
// Purpose: assertions on the bus handshake and the sequencer ports
// Assumes: sees only mscm_top ports
// Notes: bind statement after the module
`timescale 1ns/1ps
module mscm_top_props (
	input wire sys_clk, // clock
	input wire sys_rst, // sync reset
	input wire avs_read, // read strobe
	input wire avs_write, // write strobe
	input wire [31:0] avs_readdata, // read data
	input wire avs_waitrequest, // wait
	input wire cmd_done, // command done pulse
	input wire [31:0] cmd_word, // running mode word
	input wire cmd_start, // start pulse
	input wire cmd_abort, // abort pulse
	input wire sequence_busy_output // sequence running
);
	wire [7:0] jmp = cmd_word[23:16]; // jump field
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// completion events by jump code
	// ----------------------------------------
	sequence done_stop;
		cmd_done && (jmp == 8'h00);
	endsequence
	sequence done_chain;
		cmd_done && (jmp == 8'hA0 || (jmp >= 8'h01 && jmp <= 8'h44));
	endsequence
	sequence done_undef;
		cmd_done && jmp != 8'hA0 && jmp != 8'hB0 && jmp > 8'h44;
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered after one wait state");
	wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data changed without a read");
	stop_end_a: assert property (done_stop |=> !sequence_busy_output || cmd_start)
		else $error("stop code did not end the sequence");
	chain_busy_a: assert property (done_chain |=> sequence_busy_output)
		else $error("busy dropped on a chaining code");
	undef_end_a: assert property (done_undef |=> !sequence_busy_output || cmd_start)
		else $error("undefined code did not end the sequence");
	abort_start_a: assert property (cmd_abort |-> ##[0:2] cmd_start)
		else $error("abort not followed by a start");
	start_busy_a: assert property (cmd_start |=> sequence_busy_output [*2])
		else $error("busy not high after a start");
	start_pulse_a: assert property (cmd_start |=> !cmd_start)
		else $error("start longer than one cycle");
endmodule // mscm_top_props
bind mscm_top mscm_top_props mscm_top_props_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .cmd_done(cmd_done), .cmd_word(cmd_word),
	.cmd_start(cmd_start), .cmd_abort(cmd_abort), .sequence_busy_output(sequence_busy_output));

// File: verif/mscm_motion_model.sv
// Purpose: motion engine that runs each started command for lat cycles
// Assumes: a new start replaces the running command
// Notes: decel high over the last cycles, done is a one-cycle pulse
`timescale 1ns/1ps
module mscm_motion_model (
	input wire sys_clk, // clock
	input wire sys_rst, // sync reset
	input wire cmd_start, // start pulse
	input wire cmd_abort, // abort pulse
	input wire [7:0] lat, // command length in cycles
	output reg cmd_done, // done pulse
	output reg cmd_decel // decelerating
);
	reg [7:0] cnt; // cycles left
	// count down one command, abort drops it without a done
	always @(posedge sys_clk) begin
		if (sys_rst)
			cnt <= 8'h00;
		else if (cmd_start)
			cnt <= lat;
		else if (cmd_abort)
			cnt <= 8'h00;
		else if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
		cmd_done <= !sys_rst && cnt == 8'h01 && !cmd_start && !cmd_abort;
		cmd_decel <= !sys_rst && cnt != 8'h00 && cnt < 8'h10;
	end
endmodule // mscm_motion_model

// File: verif/mscm_top_bench.sv
// Purpose: self-checking bench for the sequencer and monitors
// Assumes: motion model answers each start after 30..69 cycles
// Notes: expected values worked out from integers here
`timescale 1ns/1ps
`include "mscm_consts.vh"
module mscm_top_bench;
	reg sys_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0; // clock, bus
	reg [5:0] avs_address = 6'h00; // bus address
	reg [31:0] avs_writedata = 32'h00000000, cmd_word = 32'h00000000; // data, mode word
	reg signed [31:0] abs_position = 0, encoder_position = 0; // positions
	reg servo_on = 1'b0, trigger_req = 1'b0; // pins
	reg [6:0] trigger_cmd = 7'h00; // requested command
	reg [7:0] lat = 8'h1E; // model command length
	wire [31:0] avs_readdata; // read data
	wire avs_waitrequest, cmd_done, cmd_decel, cmd_start, cmd_abort, busy, dly, irq; // outputs
	wire [6:0] cmd_number; // command to run
	wire [15:0] scale_out; // scale in use
	integer miscompares = 0, n_checks = 0, k, cp; // counters, model values
	reg [31:0] q; // last read
	mscm_top mscm_top_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.abs_position(abs_position), .encoder_position(encoder_position), .servo_on(servo_on),
		.trigger_req(trigger_req), .trigger_cmd(trigger_cmd), .cmd_done(cmd_done),
		.cmd_decel(cmd_decel), .cmd_word(cmd_word), .cmd_number(cmd_number),
		.cmd_start(cmd_start), .cmd_abort(cmd_abort), .sequence_busy_output(busy),
		.sequence_delay_output(dly), .monitor_pulse_scale_out(scale_out), .irq(irq));
	mscm_motion_model mscm_motion_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.cmd_start(cmd_start), .cmd_abort(cmd_abort), .lat(lat), .cmd_done(cmd_done),
		.cmd_decel(cmd_decel));
	// ----------------------------------------
	// clock, tasks
	// ----------------------------------------
	initial forever #20 sys_clk = ~sys_clk;
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("[ERR] %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// one bus cycle, held until waitrequest is sampled low
	task bus(input wr, input [5:0] a, input [31:0] d);
		integer i;
		begin
			@(posedge sys_clk);
			avs_address <= a;
			avs_writedata <= d;
			avs_write <= wr;
			avs_read <= !wr;
			i = 0;
			do begin
				@(posedge sys_clk);
				i = i + 1;
			end while (avs_waitrequest !== 1'b0);
			chk("bus wait", 2, i);
			q = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask
	task rd_chk(input [5:0] a, input [31:0] e, input string nm);
		begin
			bus(1'b0, a, 32'h00000000);
			chk(nm, e, q);
		end
	endtask
	// raise a trigger with a fresh command length
	task trig(input [6:0] n);
		begin
			@(posedge sys_clk);
			trigger_req <= 1'b0;
			repeat (3) @(posedge sys_clk);
			trigger_cmd <= n;
			trigger_req <= 1'b1;
			lat <= 8'h1E + 8'($urandom % 40);
		end
	endtask
	task exp_start(input [6:0] n);
		integer i;
		begin
			i = 0;
			do begin
				@(posedge sys_clk);
				i = i + 1;
			end while (cmd_start !== 1'b1 && i < 300);
			trigger_req <= 1'b0;
			chk("cmd_start", 1, {31'h0, cmd_start});
			chk("cmd_number", {25'h0, n}, {25'h0, cmd_number});
		end
	endtask
	task exp_idle;
		integer i;
		begin
			for (i = 0; i < 150; i = i + 1) begin
				@(posedge sys_clk);
				if (i == 10)
					trigger_req <= 1'b0;
				if (cmd_start === 1'b1)
					chk("no start", 0, 1);
			end
			chk("busy", 0, {31'h0, busy});
		end
	endtask
	function [31:0] jw(input [7:0] c);
		jw = {8'h00, c, 16'h0000};
	endfunction
	task finish_test;
		begin
			$display("checks %0d miscompares %0d", n_checks, miscompares);
			if (miscompares == 0 && n_checks > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		k = $urandom(36053);
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd_chk(`MSCM_A_SCALE, 32'h00000001, "scale reset");
		rd_chk(`MSCM_A_STROKE, 32'h00000000, "stroke reset");
		rd_chk(6'h3C, `MSCM_DEAD, "unmapped");
		$display("test regs done");
		bus(1'b1, `MSCM_A_CTRL, 32'h00000001);
		bus(1'b1, `MSCM_A_STROKE, 32'd4000);
		bus(1'b1, `MSCM_A_MASK, 32'h00000004);
		abs_position <= 100;
		encoder_position <= 250;
		servo_on <= 1'b1;
		repeat (60) @(posedge sys_clk);
		chk("irq", 1, {31'h0, irq});
		rd_chk(`MSCM_A_IRQ, 32'h00000004, "irq status");
		bus(1'b1, `MSCM_A_IRQ, 32'h00000004);
		repeat (3) @(posedge sys_clk);
		chk("irq", 0, {31'h0, irq});
		for (k = 0; k < 4; k = k + 1) begin
			cp = (k == 0) ? 10000 : $urandom % 100000;
			abs_position <= cp;
			repeat (100) @(posedge sys_clk);
			rd_chk(`MSCM_A_SPOS, 100, "start pos");
			rd_chk(`MSCM_A_CPOS, cp, "cur pos");
			rd_chk(`MSCM_A_SIDX, 100 % 4000, "start idx");
			rd_chk(`MSCM_A_CIDX, cp % 4000, "cur idx");
			rd_chk(`MSCM_A_CDP, cp - 100, "commanded");
			rd_chk(`MSCM_A_FBP, 250 + cp - 100, "feedback");
		end
		$display("test monitors done");
		bus(1'b1, `MSCM_A_SCALE, 32'h00000007);
		repeat (2) @(posedge sys_clk);
		chk("scale in mode", 7, {16'h0, scale_out});
		bus(1'b1, `MSCM_A_CTRL, 32'h00000000);
		repeat (2) @(posedge sys_clk);
		chk("scale fixed", 1, {16'h0, scale_out});
		bus(1'b1, `MSCM_A_CTRL, 32'h00000001);
		$display("test scale done");
		cmd_word <= jw(8'hA0);
		trig(7'd5);
		exp_start(7'd5);
		exp_start(7'd6);
		cmd_word <= jw(8'h44);
		exp_start(7'd68);
		cmd_word <= jw(8'h50);
		exp_idle;
		cmd_word <= jw(8'h00);
		trig(7'd10);
		exp_start(7'd10);
		exp_idle;
		$display("test jump done");
		trig(7'd2);
		exp_start(7'd2);
		trig(7'd9);
		exp_idle;
		bus(1'b1, `MSCM_A_CTRL, 32'h00000005);
		cmd_word <= jw(8'h00);
		trig(7'd2);
		exp_start(7'd2);
		trig(7'd9);
		exp_start(7'd9);
		exp_idle;
		bus(1'b1, `MSCM_A_CTRL, 32'h00000009);
		cmd_word <= jw(8'hB0);
		trig(7'd1);
		exp_start(7'd1);
		trig(7'd3);
		exp_start(7'd3);
		exp_start(7'd1);
		cmd_word <= jw(8'h00);
		exp_idle;
		$display("test policy done");
		bus(1'b1, `MSCM_A_CTRL, 32'h00000003);
		cmd_word <= jw(8'hA0);
		trig(7'd20);
		exp_start(7'd20);
		exp_start(7'd21);
		chk("chained in decel", 1, {31'h0, cmd_decel});
		chk("delay during run", 0, {31'h0, dly});
		cmd_word <= jw(8'h00);
		exp_idle;
		chk("delay after run", 1, {31'h0, dly});
		$display("test overlap done");
		finish_test;
	end
	initial begin
		repeat (40000) @(posedge sys_clk);
		miscompares = miscompares + 1;
		finish_test;
	end
endmodule // mscm_top_bench
